// ==== logic/event_set.sv ====
// One status set: sticky event latch, enable register, summary
`timescale 1ns/1ns
module event_set
	import status_bank_pkg::*;
#(
	parameter logic [15:0] USED = 16'hFFFF,
	parameter logic [15:0] EN_W = 16'hFFFF
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	// Events and clears
	input  wire logic [15:0] set_i,
	input  wire logic        clr_i,
	// Enable register access
	input  wire logic        en_wr_i,
	input  wire logic        en_clr_i,
	input  wire logic [15:0] en_data_i,
	// State out
	output logic      [15:0] latch_o,
	output logic      [15:0] enable_o,
	output logic             summary_o
);
	logic [15:0] latch_reg;
	logic [15:0] latch_next;
	logic [15:0] enable_reg;
	logic [15:0] enable_next;
	logic        summary_reg;

	// Set wins over a clear in the same cycle; unused bits never set
	assign latch_next  = ({16{~clr_i}} & latch_reg) | (set_i & USED);
	assign enable_next = en_wr_i  ? (en_data_i & EN_W) :
	                     en_clr_i ? REG_RESET : enable_reg;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			latch_reg   <= REG_RESET;
			enable_reg  <= REG_RESET;
			summary_reg <= 1'b0;
		end else if (ce_i) begin
			latch_reg   <= latch_next;
			enable_reg  <= enable_next;
			summary_reg <= |(latch_next & enable_next);
		end
	end

	assign latch_o   = latch_reg;
	assign enable_o  = enable_reg;
	assign summary_o = summary_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_unused_zero;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(latch_reg & ~USED) == 16'h0000;
	endproperty
	a_unused_zero: assert property (p_unused_zero) // [R24]
		else $error("unassigned event bit is set");

	property p_summary;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		summary_reg == |(latch_reg & enable_reg);
	endproperty
	a_summary: assert property (p_summary) // [R22]
		else $error("summary disagrees with events and enables");
endmodule

// ==== logic/instrument_status_event_bank.sv ====
// Status event bank: four register sets with summaries
// Function
// R01: Four independent sets: standard, operation, measurement, questionable
// R02: Bit0 only after done-command and nothing pending
// R03: Bit2 on read of empty output queue
// R04: Bit3 on internal operation failure
// R05: Bit4 on command execution error
// R06: Bit5 on syntax, unknown command, trigger-in-message
// R07: Bit6 on local key press
// R08: Bit7 after power restored since last read
// R09: Operation bits 1/2 while voltage-protected off
// R10: Operation bits 3/7 while current limited
// R11: Operation bits 4/8 on current trip off
// R12: Operation bits 5/6 on overheat shutdowns
// R13: Measurement bits 3/6 on reading over range
// R14: Measurement bits 4/7 on missing pulse
// R15: Measurement bits 5/8 on new reading
// R16: Measurement bits 9/10 on averaging done
// R17: Questionable bit8 bad calibration until recalibrated
// R18: Condition registers only for three non-standard sets
// R19: Condition registers read-only, follow live conditions
// R20: Event bits sticky; reading clears whole register
// R21: Clear-status and power-up zero all event registers
// R22: Summary is OR of events AND enables
// R23: Summaries feed status byte bits 0,3,5,7
// R24: Unassigned bits read zero, never set; enable registers still store and read back written unassigned bits; standard enable stores only bits 7:0
// R25: Live-condition events latch on rising edge
`timescale 1ns/1ns
module instrument_status_event_bank
	import status_bank_pkg::*;
(
	// Clock, reset, clock enable
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	// Register queries
	input  wire logic        rd_i,
	input  wire logic [3:0]  rd_sel_i,
	output logic      [15:0] rd_data_o,
	output logic             rd_valid_o,
	// Enable programming and clears
	input  wire logic        wr_i,
	input  wire logic [1:0]  wr_sel_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        preset_i,
	input  wire logic        clear_status_i,
	// Command parser events
	input  wire logic        done_cmd_i,
	input  wire logic        ops_pending_i,
	input  wire logic        empty_read_fault_i,
	input  wire logic        device_internal_fault_i,
	input  wire logic        run_fault_i,
	input  wire logic        syntax_err_i,
	input  wire logic        unknown_cmd_i,
	input  wire logic        trigger_in_msg_i,
	input  wire logic        local_key_request_i,
	// Output protection conditions
	input  wire logic        overvolt_off_ch1_i,
	input  wire logic        overvolt_off_ch2_i,
	input  wire logic        amp_limit_ch1_i,
	input  wire logic        amp_limit_ch2_i,
	input  wire logic        amp_trip_ch1_i,
	input  wire logic        amp_trip_ch2_i,
	input  wire logic        stage_overtemp_off_i,
	input  wire logic        mains_overtemp_off_i,
	// Measurement conditions
	input  wire logic        over_range_ch1_i,
	input  wire logic        over_range_ch2_i,
	input  wire logic        no_pulse_ch1_i,
	input  wire logic        no_pulse_ch2_i,
	input  wire logic        new_reading_ch1_i,
	input  wire logic        new_reading_ch2_i,
	input  wire logic        avg_complete_ch1_i,
	input  wire logic        avg_complete_ch2_i,
	// Calibration
	input  wire logic        cal_bad_i,
	input  wire logic        cal_ok_i,
	// Status byte summaries
	output logic             meas_summary_o,
	output logic             quest_summary_o,
	output logic             std_summary_o,
	output logic             op_summary_o
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic        done_armed_reg;
	logic        pon_pending_reg;
	logic        cal_cond_reg;
	logic [15:0] rd_data_reg;
	logic        rd_valid_reg;
	logic [15:0] std_set;
	logic [15:0] op_cond, meas_cond, quest_cond;
	logic [15:0] op_rise, meas_rise, quest_rise;
	logic [15:0] std_evt, op_evt, meas_evt, quest_evt;
	logic [15:0] std_en, op_en, meas_en, quest_en;
	logic        done_fire;
	logic [15:0] rd_mux;
	logic        std_sum, op_sum, meas_sum, quest_sum;

	function automatic logic hit(input logic req, input logic [3:0] sel,
	                             input logic [3:0] code);
		hit = req && (sel == code);
	endfunction

	// ---------------------------------------------------------------
	// Standard event sources
	// ---------------------------------------------------------------
	// Armed by the done command, fires once nothing is pending
	assign done_fire = done_armed_reg && !ops_pending_i;    // [R02]

	always_comb begin
		std_set                 = '0;
		std_set[STD_ALL_DONE]   = done_fire;                  // [R02]
		std_set[STD_EMPTY_READ] = empty_read_fault_i;         // [R03]
		std_set[STD_INTERNAL]   = device_internal_fault_i;    // [R04]
		std_set[STD_RUN]        = run_fault_i;                // [R05]
		std_set[STD_SYNTAX]     = syntax_err_i | unknown_cmd_i
		                        | trigger_in_msg_i;           // [R06]
		std_set[STD_LOCAL_KEY]  = local_key_request_i;        // [R07]
		std_set[STD_POWER]      = pon_pending_reg;            // [R08]
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done_armed_reg  <= 1'b0;
			pon_pending_reg <= 1'b1;
			cal_cond_reg    <= 1'b0;
		end else if (ce_i) begin
			done_armed_reg  <= done_cmd_i || (done_armed_reg && !done_fire);
			pon_pending_reg <= 1'b0;                          // [R08]
			// Bad constant wins over a same-cycle good calibration
			cal_cond_reg    <= cal_bad_i
			                || (cal_cond_reg && !cal_ok_i);   // [R17]
		end
	end

	// ---------------------------------------------------------------
	// Live condition vectors
	// ---------------------------------------------------------------
	always_comb begin
		op_cond                  = '0;
		op_cond[OP_OVERVOLT_CH1] = overvolt_off_ch1_i;        // [R09]
		op_cond[OP_OVERVOLT_CH2] = overvolt_off_ch2_i;        // [R09]
		op_cond[OP_LIMIT_CH1]    = amp_limit_ch1_i;           // [R10]
		op_cond[OP_LIMIT_CH2]    = amp_limit_ch2_i;           // [R10]
		op_cond[OP_TRIP_CH1]     = amp_trip_ch1_i;            // [R11]
		op_cond[OP_TRIP_CH2]     = amp_trip_ch2_i;            // [R11]
		op_cond[OP_STAGE_HOT]    = stage_overtemp_off_i;      // [R12]
		op_cond[OP_MAINS_HOT]    = mains_overtemp_off_i;      // [R12]
		meas_cond                = '0;
		meas_cond[MEAS_RANGE_CH1] = over_range_ch1_i;         // [R13]
		meas_cond[MEAS_RANGE_CH2] = over_range_ch2_i;         // [R13]
		meas_cond[MEAS_PULSE_CH1] = no_pulse_ch1_i;           // [R14]
		meas_cond[MEAS_PULSE_CH2] = no_pulse_ch2_i;           // [R14]
		meas_cond[MEAS_READ_CH1]  = new_reading_ch1_i;        // [R15]
		meas_cond[MEAS_READ_CH2]  = new_reading_ch2_i;        // [R15]
		meas_cond[MEAS_AVG_CH1]   = avg_complete_ch1_i;       // [R16]
		meas_cond[MEAS_AVG_CH2]   = avg_complete_ch2_i;       // [R16]
		quest_cond                = '0;
		quest_cond[QUEST_CAL]     = cal_cond_reg;             // [R17]
	end

	// Edges only, so a condition still present after a read is not
	// re-latched until it drops and comes back
	rise_detect #(.WIDTH(3 * REG_W)) u_cond_rise (            // [R25]
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.level_i   ({quest_cond, meas_cond, op_cond}),
		.rise_o    ({quest_rise, meas_rise, op_rise})
	);

	// ---------------------------------------------------------------
	// The four sets
	// ---------------------------------------------------------------
	event_set #(.USED(STD_USED), .EN_W(STD_EN_W)) u_std (     // [R01]
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.set_i     (std_set),
		.clr_i     (hit(rd_i, rd_sel_i, RD_STD_EVT)
		            || clear_status_i),                      // [R20] [R21]
		.en_wr_i   (wr_i && wr_sel_i == WR_STD_EN),
		.en_clr_i  (1'b0),
		.en_data_i (wr_data_i),
		.latch_o   (std_evt),
		.enable_o  (std_en),
		.summary_o (std_sum)
	);

	event_set #(.USED(OP_USED), .EN_W(FULL_EN_W)) u_op (      // [R01] [R24]
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.set_i     (op_rise),
		.clr_i     (hit(rd_i, rd_sel_i, RD_OP_EVT)
		            || clear_status_i),                      // [R20] [R21]
		.en_wr_i   (wr_i && wr_sel_i == WR_OP_EN),
		.en_clr_i  (preset_i),
		.en_data_i (wr_data_i),
		.latch_o   (op_evt),
		.enable_o  (op_en),
		.summary_o (op_sum)
	);

	event_set #(.USED(MEAS_USED), .EN_W(FULL_EN_W)) u_meas (  // [R01] [R24]
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.set_i     (meas_rise),
		.clr_i     (hit(rd_i, rd_sel_i, RD_MEAS_EVT)
		            || clear_status_i),                      // [R20] [R21]
		.en_wr_i   (wr_i && wr_sel_i == WR_MEAS_EN),
		.en_clr_i  (preset_i),
		.en_data_i (wr_data_i),
		.latch_o   (meas_evt),
		.enable_o  (meas_en),
		.summary_o (meas_sum)
	);

	event_set #(.USED(QUEST_USED), .EN_W(FULL_EN_W)) u_quest (// [R01] [R24]
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.ce_i      (ce_i),
		.set_i     (quest_rise),
		.clr_i     (hit(rd_i, rd_sel_i, RD_QUEST_EVT)
		            || clear_status_i),                      // [R20] [R21]
		.en_wr_i   (wr_i && wr_sel_i == WR_QUEST_EN),
		.en_clr_i  (preset_i),
		.en_data_i (wr_data_i),
		.latch_o   (quest_evt),
		.enable_o  (quest_en),
		.summary_o (quest_sum)
	);

	// ---------------------------------------------------------------
	// Query answer
	// ---------------------------------------------------------------
	// No standard condition code exists; unmapped selects read zero
	assign rd_mux =
		(rd_sel_i == RD_STD_EVT)    ? std_evt    :
		(rd_sel_i == RD_OP_EVT)     ? op_evt     :
		(rd_sel_i == RD_MEAS_EVT)   ? meas_evt   :
		(rd_sel_i == RD_QUEST_EVT)  ? quest_evt  :
		(rd_sel_i == RD_OP_COND)    ? op_cond    :            // [R18] [R19]
		(rd_sel_i == RD_MEAS_COND)  ? meas_cond  :            // [R19]
		(rd_sel_i == RD_QUEST_COND) ? quest_cond :            // [R19]
		(rd_sel_i == RD_STD_EN)     ? std_en     :
		(rd_sel_i == RD_OP_EN)      ? op_en      :
		(rd_sel_i == RD_MEAS_EN)    ? meas_en    :
		(rd_sel_i == RD_QUEST_EN)   ? quest_en   : REG_RESET;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_reg  <= REG_RESET;
			rd_valid_reg <= 1'b0;
		end else if (ce_i) begin
			rd_valid_reg <= rd_i;
			if (rd_i) begin
				rd_data_reg <= rd_mux;
			end
		end
	end

	assign rd_data_o       = rd_data_reg;
	assign rd_valid_o      = rd_valid_reg;
	assign meas_summary_o  = meas_sum;                        // [R22] [R23]
	assign quest_summary_o = quest_sum;                       // [R23]
	assign std_summary_o   = std_sum;                         // [R23]
	assign op_summary_o    = op_sum;                          // [R23]

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_done_cause;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		$rose(std_evt[STD_ALL_DONE]) |-> $past(done_fire);
	endproperty
	a_done_cause: assert property (p_done_cause) // [R02]
		else $error("all-done flag set without cause");

	property p_power_seen;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		$fell(pon_pending_reg) |-> std_evt[STD_POWER];
	endproperty
	a_power_seen: assert property (p_power_seen) // [R08]
		else $error("power cycle bit not set after reset");

	property p_limit_rise;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && amp_limit_ch1_i && !$past(amp_limit_ch1_i)
		&& op_rise[OP_LIMIT_CH1] |=> op_evt[OP_LIMIT_CH1];
	endproperty
	a_limit_rise: assert property (p_limit_rise) // [R25]
		else $error("current limit edge not latched");

	property p_read_clears;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && rd_i && rd_sel_i == RD_OP_EVT && op_rise == 16'h0000
		|=> op_evt == 16'h0000 && rd_valid_o;
	endproperty
	a_read_clears: assert property (p_read_clears) // [R20]
		else $error("event read did not clear");

	property p_cls_clears;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && clear_status_i && std_set == 16'h0000
		|=> std_evt == 16'h0000;
	endproperty
	a_cls_clears: assert property (p_cls_clears) // [R21]
		else $error("clear status left standard events");

	property p_cond_read;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && rd_i && rd_sel_i == RD_MEAS_COND
		|=> rd_valid_o && rd_data_o == $past(meas_cond);
	endproperty
	a_cond_read: assert property (p_cond_read) // [R19]
		else $error("condition read returned stale data");

	property p_cal_hold;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && cal_cond_reg && !cal_ok_i |=> cal_cond_reg;
	endproperty
	a_cal_hold: assert property (p_cal_hold) // [R17]
		else $error("calibration flag dropped early");

	property p_std_no_cond;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		ce_i && rd_i && rd_sel_i == 4'hB |=> rd_data_o == 16'h0000;
	endproperty
	a_std_no_cond: assert property (p_std_no_cond) // [R18]
		else $error("unmapped select returned data");
endmodule

// ==== logic/rise_detect.sv ====
// Rising-edge detector for a vector of live condition levels
`timescale 1ns/1ns
module rise_detect #(
	parameter int unsigned WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             ce_i,
	// Levels in, one-cycle rise out
	input  wire logic [WIDTH-1:0] level_i,
	output logic      [WIDTH-1:0] rise_o
);
	logic [WIDTH-1:0] prev_reg;

	// A level already high at reset release counts as a rise
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_reg <= '0;
		end else if (ce_i) begin
			prev_reg <= level_i;
		end
	end

	assign rise_o = level_i & ~prev_reg;
endmodule

// ==== logic/status_bank_pkg.sv ====
// Constants for the instrument status event bank
package status_bank_pkg;

	localparam int unsigned REG_W = 16;

	// ---------------------------------------------------------------
	// Query selects
	// ---------------------------------------------------------------
	localparam logic [3:0] RD_STD_EVT    = 4'h0;
	localparam logic [3:0] RD_OP_EVT     = 4'h1;
	localparam logic [3:0] RD_MEAS_EVT   = 4'h2;
	localparam logic [3:0] RD_QUEST_EVT  = 4'h3;
	localparam logic [3:0] RD_OP_COND    = 4'h4;
	localparam logic [3:0] RD_MEAS_COND  = 4'h5;
	localparam logic [3:0] RD_QUEST_COND = 4'h6;
	localparam logic [3:0] RD_STD_EN     = 4'h7;
	localparam logic [3:0] RD_OP_EN      = 4'h8;
	localparam logic [3:0] RD_MEAS_EN    = 4'h9;
	localparam logic [3:0] RD_QUEST_EN   = 4'hA;

	// ---------------------------------------------------------------
	// Enable-register program selects
	// ---------------------------------------------------------------
	localparam logic [1:0] WR_STD_EN   = 2'h0;
	localparam logic [1:0] WR_OP_EN    = 2'h1;
	localparam logic [1:0] WR_MEAS_EN  = 2'h2;
	localparam logic [1:0] WR_QUEST_EN = 2'h3;

	// ---------------------------------------------------------------
	// Standard event bit positions
	// ---------------------------------------------------------------
	localparam int unsigned STD_ALL_DONE   = 0;
	localparam int unsigned STD_EMPTY_READ = 2;
	localparam int unsigned STD_INTERNAL   = 3;
	localparam int unsigned STD_RUN        = 4;
	localparam int unsigned STD_SYNTAX     = 5;
	localparam int unsigned STD_LOCAL_KEY  = 6;
	localparam int unsigned STD_POWER      = 7;

	// ---------------------------------------------------------------
	// Operation bit positions
	// ---------------------------------------------------------------
	localparam int unsigned OP_OVERVOLT_CH1 = 1;
	localparam int unsigned OP_OVERVOLT_CH2 = 2;
	localparam int unsigned OP_LIMIT_CH1    = 3;
	localparam int unsigned OP_TRIP_CH1     = 4;
	localparam int unsigned OP_STAGE_HOT    = 5;
	localparam int unsigned OP_MAINS_HOT    = 6;
	localparam int unsigned OP_LIMIT_CH2    = 7;
	localparam int unsigned OP_TRIP_CH2     = 8;

	// ---------------------------------------------------------------
	// Measurement bit positions
	// ---------------------------------------------------------------
	localparam int unsigned MEAS_RANGE_CH1 = 3;
	localparam int unsigned MEAS_PULSE_CH1 = 4;
	localparam int unsigned MEAS_READ_CH1  = 5;
	localparam int unsigned MEAS_RANGE_CH2 = 6;
	localparam int unsigned MEAS_PULSE_CH2 = 7;
	localparam int unsigned MEAS_READ_CH2  = 8;
	localparam int unsigned MEAS_AVG_CH1   = 9;
	localparam int unsigned MEAS_AVG_CH2   = 10;

	// Questionable bit position
	localparam int unsigned QUEST_CAL = 8;

	// ---------------------------------------------------------------
	// Used-bit and writable-enable masks
	// ---------------------------------------------------------------
	localparam logic [15:0] STD_USED   = 16'h00FD;
	localparam logic [15:0] STD_EN_W   = 16'h00FF;
	localparam logic [15:0] OP_USED    = 16'h01FE;
	localparam logic [15:0] MEAS_USED  = 16'h07F8;
	localparam logic [15:0] QUEST_USED = 16'h0100;
	localparam logic [15:0] FULL_EN_W  = 16'hFFFF;

	// Reset values
	localparam logic [15:0] REG_RESET = 16'h0000;

endpackage

// ==== tb/host_query.sv ====
// Host controller model that issues status queries
`timescale 1ns/1ns
module host_query (
	// Clock and answer
	input  wire logic        clk_sys_i,
	input  wire logic [15:0] rd_data_i,
	input  wire logic        rd_valid_i,
	// Query request
	output logic             rd_o,
	output logic      [3:0]  rd_sel_o
);
	initial begin
		rd_o = 1'b0;
		rd_sel_o = 4'hF;
	end
	// Select is scrambled after the take, so a stale one is never read
	task automatic query(input logic [3:0] s, output logic [15:0] d,
		output logic v);
		@(posedge clk_sys_i);
		#5;
		rd_o = 1'b1;
		rd_sel_o = s;
		@(posedge clk_sys_i);
		#5;
		rd_o = 1'b0;
		rd_sel_o = ~s;
		v = rd_valid_i;
		d = rd_data_i;
	endtask
endmodule

// ==== tb/instrument_status_event_bank_bench.sv ====
// Self-checking bench for the status event bank
`timescale 1ns/1ns
module instrument_status_event_bank_bench;
	import status_bank_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, pend = 1'b0, qc, arm, pw, v;
	logic        ce = 1'b1, qp;
	logic [15:0] ow = '0, mw = '0, wd = '0, got, ex, op_p, me_p;
	logic [15:0] std_m, op_m, me_m, q_m, en_m [4], vw [16];
	logic [7:0]  sp = '0;
	logic [6:0]  cw = '0;
	logic [1:0]  ws = '0;
	wire  [15:0] rdat;
	wire  [3:0]  sel, sm;
	wire         rd, rv;
	int          miscompares = 0, check_count = 0, cyc = 0, i;

	instrument_status_event_bank instrument_status_event_bank_inst (
		.clk_sys_i(clk), .resetn_i(rstn), .ce_i(ce), .rd_i(rd),
		.rd_sel_i(sel), .rd_data_o(rdat), .rd_valid_o(rv), .wr_i(cw[0]),
		.wr_sel_i(ws), .wr_data_i(wd), .preset_i(cw[1]),
		.clear_status_i(cw[2]), .done_cmd_i(sp[0]), .ops_pending_i(pend),
		.empty_read_fault_i(sp[1]), .device_internal_fault_i(sp[2]),
		.run_fault_i(sp[3]), .syntax_err_i(sp[4]), .unknown_cmd_i(sp[5]),
		.trigger_in_msg_i(sp[6]), .local_key_request_i(sp[7]),
		.overvolt_off_ch1_i(ow[1]), .overvolt_off_ch2_i(ow[2]),
		.amp_limit_ch1_i(ow[3]), .amp_trip_ch1_i(ow[4]),
		.stage_overtemp_off_i(ow[5]), .mains_overtemp_off_i(ow[6]),
		.amp_limit_ch2_i(ow[7]), .amp_trip_ch2_i(ow[8]),
		.over_range_ch1_i(mw[3]), .no_pulse_ch1_i(mw[4]),
		.new_reading_ch1_i(mw[5]), .over_range_ch2_i(mw[6]),
		.no_pulse_ch2_i(mw[7]), .new_reading_ch2_i(mw[8]),
		.avg_complete_ch1_i(mw[9]), .avg_complete_ch2_i(mw[10]),
		.cal_bad_i(cw[3]), .cal_ok_i(cw[4]), .meas_summary_o(sm[0]),
		.quest_summary_o(sm[1]), .std_summary_o(sm[2]), .op_summary_o(sm[3])
	);
	host_query host_query_inst (.clk_sys_i(clk), .rd_data_i(rdat),
		.rd_valid_i(rv), .rd_o(rd), .rd_sel_o(sel));

	initial forever #25 clk = ~clk;

	// Ceiling runs on every rising edge, so a stuck enable cannot hang the run
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ---------------------------------------------------------------
	// Reference model, one update per clock edge while ce is high
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{std_m, op_m, me_m, q_m, op_p, me_p} = '0;
			{qc, qp, arm, pw} = 4'b0001;
			en_m = '{default: '0};
		end else if (ce) begin
			// Index order follows the query select codes
			vw = '{std_m, op_m, me_m, q_m, ow & OP_USED, mw & MEAS_USED,
				{7'h00, qc, 8'h00}, en_m[0], en_m[1], en_m[2], en_m[3],
				'0, '0, '0, '0, '0};
			if (rd) ex = vw[sel];
			if (cw[2] || (rd && sel == RD_STD_EVT)) std_m = '0;
			if (cw[2] || (rd && sel == RD_OP_EVT)) op_m = '0;
			if (cw[2] || (rd && sel == RD_MEAS_EVT)) me_m = '0;
			if (cw[2] || (rd && sel == RD_QUEST_EVT)) q_m = '0;
			// Sets are applied after clears, so a set wins
			std_m |= {8'h00, pw, sp[7], |sp[6:4], sp[3:1], 1'b0, arm & ~pend};
			arm = (arm & pend) | sp[0];
			pw = 1'b0;
			op_m |= ow & ~op_p & OP_USED;
			me_m |= mw & ~me_p & MEAS_USED;
			op_p = ow;
			me_p = mw;
			// Event follows the rise of the held calibration condition
			q_m[8] |= qc & ~qp;
			qp = qc;
			qc = cw[3] | (qc & ~cw[4]);
			if (cw[1]) {en_m[1], en_m[2], en_m[3]} = '0;
			if (cw[0]) en_m[ws] = (ws == WR_STD_EN) ? (wd & 16'h00FF) : wd;
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rdq(input logic [3:0] s);
		host_query_inst.query(s, got, v);
		chk("rd_valid", 16'h0001, {15'h0000, v});
		chk("rd_data", ex, got);
	endtask

	task automatic drive(input logic [15:0] o, m, input logic [7:0] s,
		input logic [6:0] c);
		@(posedge clk);
		#5;
		{ow, mw, sp, cw} = {o, m, s, c};
		@(posedge clk);
		#5;
		{sp, cw} = '0;
		chk("summary", {12'h000, |(op_m & en_m[1]), |(std_m & en_m[0]),
			|(q_m & en_m[3]), |(me_m & en_m[2])}, {12'h000, sm});
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		got = $urandom(32'h1DD6);
		repeat (2) @(posedge clk);
		#5;
		rstn = 1'b1;
		rdq(RD_STD_EVT);
		rdq(RD_STD_EVT);
		for (i = 1; i < 8; i++) begin
			drive(ow, mw, 8'(1 << i), '0);
			rdq(RD_STD_EVT);
		end
		pend = 1'b1;
		drive(ow, mw, 8'h01, '0);
		drive(ow, mw, '0, '0);
		rdq(RD_STD_EVT);
		pend = 1'b0;
		drive(ow, mw, '0, '0);
		rdq(RD_STD_EVT);
		drive('1, '1, '0, '0);
		rdq(RD_OP_EVT);
		rdq(RD_MEAS_EVT);
		rdq(RD_OP_EVT);
		rdq(RD_OP_COND);
		rdq(RD_MEAS_COND);
		drive('0, '0, '0, '0);
		rdq(RD_OP_COND);
		rdq(RD_MEAS_COND);
		{ws, wd} = {WR_STD_EN, 16'hFFFF};
		drive(ow, mw, 8'h80, 7'h01);
		drive(ow, mw, '0, 7'h04);
		rdq(RD_STD_EN);
		drive(ow, mw, '0, 7'h02);
		drive(ow, mw, '0, 7'h08);
		drive(ow, mw, '0, '0);
		rdq(RD_QUEST_COND);
		rdq(RD_QUEST_EVT);
		drive(ow, mw, '0, 7'h10);
		rdq(RD_QUEST_COND);
		for (i = 11; i < 16; i++) rdq(4'(i));
		// Frozen enable: trigger-in-message lost, limit rise seen once running
		ce = 1'b0;
		drive(16'h0008, mw, 8'h40, '0);
		ce = 1'b1;
		rdq(RD_STD_EVT);
		rdq(RD_OP_EVT);
		for (i = 0; i < 60; i++) begin
			pend = 1'($urandom);
			{ws, wd} = 18'($urandom);
			drive(16'($urandom), 16'($urandom), 8'($urandom),
				7'($urandom) & 7'h07);
			rdq(4'($urandom_range(15)));
		end
		report_and_stop();
	end
endmodule
